// [hdl/isas_pkg.sv]
// Constants and types for the init sequencer and address select block
package isas_pkg;

	// ************************************************
	// Widths
	// ************************************************
	localparam int CFG_WORDS = 16;
	localparam int CFG_AW = 4;
	localparam int CFG_W = 8;
	localparam int ADC_W = 10;
	localparam int OFS_W = 4;
	localparam int BA_W = 7;
	localparam int AXI_AW = 12;
	localparam int AXI_DW = 32;

	// ************************************************
	// Working configuration layout
	// ************************************************
	localparam logic [CFG_AW-1:0] CFG_I2C_BASE = 4'h0;
	localparam logic [CFG_AW-1:0] CFG_PMB_BASE = 4'h1;
	localparam logic [CFG_AW-1:0] CFG_EN_CTRL = 4'h2;
	localparam logic [CFG_AW-1:0] CFG_LAST = 4'hf;
	localparam int EN_USE_SW_BIT = 0;
	localparam int EN_SW_ON_BIT = 1;
	localparam logic [BA_W-1:0] I2C_BASE_RST = 7'h10;
	localparam logic [BA_W-1:0] PMB_BASE_RST = 7'h40;
	localparam logic [CFG_W-1:0] CFG_OTHER_RST = 8'h00;

	// ************************************************
	// Register map (byte addresses)
	// ************************************************
	localparam logic [AXI_AW-1:0] REG_STATUS = 12'h040;
	localparam logic [AXI_AW-1:0] REG_EFF_ADDR = 12'h044;
	localparam int STS_LOAD_DONE = 0;
	localparam int STS_ADDR_DONE = 1;
	localparam int STS_ANALOG = 2;
	localparam int STS_CONV_EN = 3;
	localparam int STS_POR = 4;
	localparam int STS_OFS_LSB = 8;
	localparam int EFF_PMB_LSB = 8;
	localparam int EFF_I2C_EN = 16;
	localparam int EFF_PMB_EN = 17;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ************************************************
	// Strap decode thresholds, ascending
	// ************************************************
	localparam logic [14:0][ADC_W-1:0] STRAP_THR = {
		10'h383, 10'h331, 10'h2e8, 10'h29d, 10'h251,
		10'h208, 10'h1c2, 10'h186, 10'h14e, 10'h11a,
		10'h0ea, 10'h0ba, 10'h08f, 10'h067, 10'h03e
	};
	localparam logic [ADC_W-1:0] STRAP_FLOAT_THR = 10'h3e8;

	typedef enum logic [2:0] {
		ST_POR_HOLD = 3'b000,
		ST_NV_LOAD = 3'b001,
		ST_ADC_KICK = 3'b010,
		ST_ADC_WAIT = 3'b011,
		ST_RUN = 3'b100
	} isas_state_t;

endpackage : isas_pkg

// [hdl/isas_strap_decode.sv]
// Strap converter reading to address offset and floating detect
`timescale 1ns/10ps
`default_nettype none
module isas_strap_decode
	import isas_pkg::*;
(
	input wire logic [ADC_W-1:0] code_i,
	output logic [OFS_W-1:0] offset_o,
	output logic floating_o
);

	// Offset is the count of midpoint thresholds the reading reaches
	always_comb begin
		offset_o = 4'h0;
		for (int i = 0; i < 15; i++) begin
			if (code_i >= STRAP_THR[i]) begin
				offset_o = offset_o + 4'h1; // R9 R15
			end
		end
	end

	assign floating_o = (code_i >= STRAP_FLOAT_THR); // R15

endmodule : isas_strap_decode
`default_nettype wire

// [hdl/isas_init_seq.sv]
// Power-up load sequencer, strap address select and enable gating
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Overview of operation
// [R1] Internal reset holds while bias or core rail is low or clock unstable.
// [R2] Leaving reset starts a copy of all nonvolatile words into working regs.
// [R3] After the load, bus writes may rewrite working parameters at any enable; code refuses them until addr_done (strap sampled).
// [R4] By default conversion needs enable pin, input UV ok, load and address.
// [R5] In digital mode software enable options replace the pin condition.
// [R6] Two 7-bit base address registers exist, one per interface.
// [R7] A zero base address disables that interface.
// [R8] Base addresses reset to 0x10 for I2C and 0x40 for PMBus.
// [R9] The strap decodes to one of sixteen offsets, rising with resistance.
// [R10] The strap is sampled once by the converter during initialization.
// [R11] In digital mode only base plus offset is answered.
// [R12] A floating strap disables digital communication entirely.
// [R13] In analog mode the three communication pins switch to analog use.
// [R14] In analog mode the loaded configuration cannot be changed.
// [R15] Thresholds sit midway between table codes; near full scale floats.
// [R16] Effective address is base plus offset, wrapped to 7 bits.
// ************************************************
module isas_init_seq
	import isas_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic bias_supply_ok_i,
	input wire logic core_supply_rail_ok_i,
	input wire logic osc_stable_i,
	output logic por_active_o,
	output logic nvm_req_o,
	output logic [CFG_AW-1:0] nvm_addr_o,
	input wire logic nvm_ack_i,
	input wire logic [CFG_W-1:0] nvm_data_i,
	output logic adc_start_o,
	input wire logic adc_done_i,
	input wire logic [ADC_W-1:0] adc_code_i,
	input wire logic enable_mode_pin_i,
	input wire logic vin_uv_ok_i,
	output logic convert_en_o,
	output logic comm_pins_analog_o,
	output logic [BA_W-1:0] i2c_addr_o,
	output logic i2c_en_o,
	output logic [BA_W-1:0] pmbus_addr_o,
	output logic pmbus_en_o,
	input wire logic [BA_W-1:0] bus_addr_i,
	input wire logic bus_addr_valid_i,
	input wire logic bus_is_pmbus_i,
	output logic bus_ack_o,
	input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [AXI_DW-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AXI_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [AXI_DW-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	// ************************************************
	// Declarations
	// ************************************************
	isas_state_t state_ff;
	isas_state_t nxt_state;
	logic por_active;
	logic load_done;
	logic addr_done;
	logic [CFG_AW-1:0] nvm_idx_ff;
	logic [CFG_W-1:0] cfg_ff [CFG_WORDS];
	logic [OFS_W-1:0] offset_ff;
	logic analog_ff;
	logic [OFS_W-1:0] dec_offset;
	logic dec_floating;
	logic [BA_W-1:0] i2c_base;
	logic [BA_W-1:0] pmb_base;
	logic sw_mode;
	logic nxt_conv;
	logic conv_en_ff;
	logic [BA_W-1:0] i2c_addr_ff;
	logic [BA_W-1:0] pmb_addr_ff;
	logic i2c_en_ff;
	logic pmb_en_ff;
	logic aw_got_ff;
	logic w_got_ff;
	logic [AXI_AW-1:0] awaddr_ff;
	logic [CFG_W-1:0] wdata_ff;
	logic wstrb0_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic wr_go;
	logic wr_cfg;
	logic wr_ro;
	logic wr_allowed;
	logic cfg_we;
	logic rvalid_ff;
	logic [AXI_DW-1:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [AXI_DW-1:0] rd_data;
	logic [1:0] rd_resp;
	logic [1:0] adc_starts_ff;

	// ************************************************
	// Reset and load sequencer
	// ************************************************
	assign por_active = !(bias_supply_ok_i && core_supply_rail_ok_i &&
		osc_stable_i); // R1
	assign load_done = (state_ff == ST_ADC_KICK) ||
		(state_ff == ST_ADC_WAIT) || (state_ff == ST_RUN);
	assign addr_done = (state_ff == ST_RUN);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_POR_HOLD: nxt_state = ST_NV_LOAD; // R2
			ST_NV_LOAD: begin
				if (nvm_ack_i && nvm_idx_ff == CFG_LAST) begin
					nxt_state = ST_ADC_KICK;
				end
			end
			ST_ADC_KICK: nxt_state = ST_ADC_WAIT;
			ST_ADC_WAIT: begin
				if (adc_done_i) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: nxt_state = ST_RUN;
			default: nxt_state = ST_POR_HOLD;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i || por_active) begin
			state_ff <= ST_POR_HOLD; // R1
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i || state_ff == ST_POR_HOLD) begin
			nvm_idx_ff <= 4'h0;
		end else if (state_ff == ST_NV_LOAD && nvm_ack_i) begin
			nvm_idx_ff <= nvm_idx_ff + 4'h1; // R2
		end
	end

	assign nvm_req_o = (state_ff == ST_NV_LOAD);
	assign nvm_addr_o = nvm_idx_ff;
	assign adc_start_o = (state_ff == ST_ADC_KICK); // R10
	assign por_active_o = por_active;

	// ************************************************
	// Strap sample, taken once per initialization
	// ************************************************
	isas_strap_decode u_strap (
		.code_i(adc_code_i),
		.offset_o(dec_offset),
		.floating_o(dec_floating)
	);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i || state_ff == ST_POR_HOLD) begin
			offset_ff <= 4'h0;
			analog_ff <= 1'b0;
		end else if (state_ff == ST_ADC_WAIT && adc_done_i) begin
			offset_ff <= dec_offset; // R9 R10
			analog_ff <= dec_floating; // R12
		end
	end

	assign comm_pins_analog_o = analog_ff; // R13

	// ************************************************
	// Working configuration array
	// ************************************************
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < CFG_WORDS; i++) begin
				cfg_ff[i] <= CFG_OTHER_RST;
			end
			cfg_ff[CFG_I2C_BASE] <= {1'b0, I2C_BASE_RST}; // R8
			cfg_ff[CFG_PMB_BASE] <= {1'b0, PMB_BASE_RST}; // R8
		end else if (state_ff == ST_NV_LOAD && nvm_ack_i) begin
			cfg_ff[nvm_idx_ff] <= (nvm_idx_ff < 4'h2) ?
				{1'b0, nvm_data_i[6:0]} : nvm_data_i; // R2 R6
		end else if (cfg_we) begin
			cfg_ff[awaddr_ff[5:2]] <= (awaddr_ff[5:2] < 4'h2) ?
				{1'b0, wdata_ff[6:0]} : wdata_ff; // R3
		end
	end

	assign i2c_base = cfg_ff[CFG_I2C_BASE][6:0];
	assign pmb_base = cfg_ff[CFG_PMB_BASE][6:0];
	assign sw_mode = !analog_ff && cfg_ff[CFG_EN_CTRL][EN_USE_SW_BIT];

	// ************************************************
	// Addresses and conversion enable
	// ************************************************
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			i2c_addr_ff <= 7'h00;
			pmb_addr_ff <= 7'h00;
			i2c_en_ff <= 1'b0;
			pmb_en_ff <= 1'b0;
		end else begin
			i2c_addr_ff <= i2c_base + {3'b000, offset_ff}; // R16
			pmb_addr_ff <= pmb_base + {3'b000, offset_ff}; // R16
			i2c_en_ff <= addr_done && !analog_ff && i2c_base != 7'h00; // R7
			pmb_en_ff <= addr_done && !analog_ff && pmb_base != 7'h00; // R7
		end
	end

	assign i2c_addr_o = i2c_addr_ff;
	assign pmbus_addr_o = pmb_addr_ff;
	assign i2c_en_o = i2c_en_ff;
	assign pmbus_en_o = pmb_en_ff;

	// Only the matching, enabled interface answers
	assign bus_ack_o = bus_addr_valid_i && (bus_is_pmbus_i ?
		(pmb_en_ff && bus_addr_i == pmb_addr_ff) :
		(i2c_en_ff && bus_addr_i == i2c_addr_ff)); // R11 R12

	always_comb begin
		if (sw_mode) begin
			nxt_conv = load_done && addr_done && vin_uv_ok_i &&
				cfg_ff[CFG_EN_CTRL][EN_SW_ON_BIT]; // R5
		end else begin
			nxt_conv = enable_mode_pin_i && vin_uv_ok_i && load_done &&
				addr_done; // R4
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			conv_en_ff <= 1'b0;
		end else begin
			conv_en_ff <= nxt_conv;
		end
	end

	assign convert_en_o = conv_en_ff;

	// ************************************************
	// AXI4-Lite write channel
	// ************************************************
	assign s_axi_awready_o = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready_o = !w_got_ff && !bvalid_ff;
	assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_cfg = (awaddr_ff < REG_STATUS) && (awaddr_ff[1:0] == 2'b00);
	assign wr_ro = (awaddr_ff == REG_STATUS) || (awaddr_ff == REG_EFF_ADDR);
	assign wr_allowed = addr_done && !analog_ff; // R3 R14
	assign cfg_we = wr_go && wr_cfg && wr_allowed && wstrb0_ff;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			aw_got_ff <= 1'b0;
			awaddr_ff <= 12'h000;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_got_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr_i;
		end else if (wr_go) begin
			aw_got_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			w_got_ff <= 1'b0;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_got_ff <= 1'b1;
			wdata_ff <= s_axi_wdata_i[7:0];
			wstrb0_ff <= s_axi_wstrb_i[0];
		end else if (wr_go) begin
			w_got_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= ((wr_cfg && wr_allowed) || wr_ro) ?
				RESP_OKAY : RESP_SLVERR; // R12 R14
		end else if (s_axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;

	// ************************************************
	// AXI4-Lite read channel
	// ************************************************
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_resp = RESP_OKAY;
		if (s_axi_araddr_i[1:0] != 2'b00) begin
			rd_resp = RESP_SLVERR;
		end else if (s_axi_araddr_i < REG_STATUS) begin
			rd_data[CFG_W-1:0] = cfg_ff[s_axi_araddr_i[5:2]];
		end else if (s_axi_araddr_i == REG_STATUS) begin
			rd_data[STS_LOAD_DONE] = load_done;
			rd_data[STS_ADDR_DONE] = addr_done;
			rd_data[STS_ANALOG] = analog_ff;
			rd_data[STS_CONV_EN] = conv_en_ff;
			rd_data[STS_POR] = (state_ff == ST_POR_HOLD);
			rd_data[STS_OFS_LSB +: OFS_W] = offset_ff;
		end else if (s_axi_araddr_i == REG_EFF_ADDR) begin
			rd_data[BA_W-1:0] = i2c_addr_ff;
			rd_data[EFF_PMB_LSB +: BA_W] = pmb_addr_ff;
			rd_data[EFF_I2C_EN] = i2c_en_ff;
			rd_data[EFF_PMB_EN] = pmb_en_ff;
		end else begin
			rd_resp = RESP_SLVERR;
		end
	end

	assign s_axi_arready_o = !rvalid_ff;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_data;
			rresp_ff <= rd_resp;
		end else if (s_axi_rready_i) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o = rdata_ff;
	assign s_axi_rresp_o = rresp_ff;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i || state_ff == ST_POR_HOLD) begin
			adc_starts_ff <= 2'b00;
		end else if (adc_start_o && adc_starts_ff != 2'b11) begin
			adc_starts_ff <= adc_starts_ff + 2'b01;
		end
	end

	sequence s_released;
		state_ff == ST_POR_HOLD && !por_active;
	endsequence
	sequence s_load_begun;
		nvm_req_o && nvm_addr_o == 4'h0;
	endsequence

	a_por_hold_state: assert property (por_active |=> // R1
		state_ff == ST_POR_HOLD ##1 !convert_en_o)
		else $error("sequencer left reset hold while supplies not ready");
	a_load_after_release: assert property (s_released |=> s_load_begun) // R2
		else $error("load did not start after reset release");
	a_write_gate: assert property (wr_go && wr_cfg && !wr_allowed |=> // R3
		s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR)
		else $error("refused config write not answered with error");
	a_conv_default_gate: assert property (!sw_mode && // R4
		!(enable_mode_pin_i && vin_uv_ok_i && addr_done) |=> !convert_en_o)
		else $error("conversion enabled without default conditions");
	a_sw_enable_use: assert property (sw_mode && addr_done && // R5
		vin_uv_ok_i && cfg_ff[CFG_EN_CTRL][EN_SW_ON_BIT] |=> convert_en_o)
		else $error("software enable option not honoured");
	a_zero_base_off: assert property (i2c_en_o |-> $past(i2c_base) != 7'h00) // R7
		else $error("I2C enabled with zero base address");
	a_strap_sample_once: assert property (adc_starts_ff <= 2'b01) // R10
		else $error("strap sampled more than once");
	a_eff_addr_sum: assert property (i2c_en_o |-> // R16
		i2c_addr_o == 7'($past(i2c_base) + {3'b000, $past(offset_ff)}))
		else $error("effective I2C address is not base plus offset");
	a_float_analog: assert property (state_ff == ST_ADC_WAIT && // R12
		adc_done_i && adc_code_i >= STRAP_FLOAT_THR |=> comm_pins_analog_o
		##1 !i2c_en_o && !pmbus_en_o)
		else $error("floating strap did not select analog mode");
	a_offset_top: assert property (state_ff == ST_ADC_WAIT && adc_done_i && // R9
		adc_code_i >= STRAP_THR[14] && adc_code_i < STRAP_FLOAT_THR
		|=> offset_ff == 4'hf)
		else $error("highest strap reading did not give offset 15");
	a_analog_frozen: assert property (analog_ff && addr_done |=> // R14
		$stable(cfg_ff[CFG_I2C_BASE]) && $stable(cfg_ff[CFG_EN_CTRL]))
		else $error("working config changed in analog mode");
	a_ack_match: assert property (bus_ack_o |-> !analog_ff && // R11
		(bus_addr_i == i2c_addr_o || bus_addr_i == pmbus_addr_o))
		else $error("bus answered at a foreign address");

endmodule : isas_init_seq
`default_nettype wire

// [tb/isas_nv_adc_model.sv]
// Behavioural nonvolatile store and strap converter facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module isas_nv_adc_model
	import isas_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic slow_i,
	input wire logic [CFG_WORDS-1:0][CFG_W-1:0] mem_i,
	input wire logic [ADC_W-1:0] strap_code_i,
	input wire logic nvm_req_i,
	input wire logic [CFG_AW-1:0] nvm_addr_i,
	output logic nvm_ack_o,
	output logic [CFG_W-1:0] nvm_data_o,
	input wire logic adc_start_i,
	output logic adc_done_o,
	output logic [ADC_W-1:0] adc_code_o
);
	logic [3:0] nvm_wait_ff = 4'h0;
	logic [3:0] adc_wait_ff = 4'h0;
	logic adc_busy_ff = 1'b0;
	logic [CFG_W-1:0] last_data_ff = 8'h5a;
	logic [ADC_W-1:0] last_code_ff = 10'h2a5;

	// ************************************************
	// Word store: one word per ack, with an optional stall
	// ************************************************
	always_ff @(posedge mclk_i) begin
		nvm_ack_o <= 1'b0;
		if (!resetn_i || !nvm_req_i || nvm_ack_o) begin
			nvm_wait_ff <= slow_i ? 4'h5 : 4'h0;
		end else if (nvm_wait_ff != 4'h0) begin
			nvm_wait_ff <= nvm_wait_ff - 4'h1;
		end else begin
			nvm_ack_o <= 1'b1;
		end
		if (nvm_ack_o) begin
			last_data_ff <= nvm_data_o;
		end
	end
	// Data bus shows a changed value whenever no word is offered
	assign nvm_data_o = nvm_ack_o ? mem_i[nvm_addr_i] : ~last_data_ff;

	// ************************************************
	// Strap converter: one reading per start request
	// ************************************************
	always_ff @(posedge mclk_i) begin
		adc_done_o <= 1'b0;
		if (!resetn_i) begin
			adc_busy_ff <= 1'b0;
		end else if (adc_start_i) begin
			adc_busy_ff <= 1'b1;
			adc_wait_ff <= slow_i ? 4'h9 : 4'h1;
		end else if (adc_busy_ff && adc_wait_ff != 4'h0) begin
			adc_wait_ff <= adc_wait_ff - 4'h1;
		end else if (adc_busy_ff) begin
			adc_busy_ff <= 1'b0;
			adc_done_o <= 1'b1;
			last_code_ff <= strap_code_i;
		end
	end
	assign adc_code_o = adc_done_o ? last_code_ff : ~last_code_ff;
endmodule : isas_nv_adc_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the init sequencer and address select block
`timescale 1ns/10ps
`default_nettype none
module testbench
	import isas_pkg::*;
;
	logic mclk_i, resetn_i = 1'b0, bias_ok = 1'b0, core_ok = 1'b0;
	logic osc_ok = 1'b0, pin = 1'b0, uv = 1'b0, slow = 1'b0;
	logic bvld = 1'b0, bpm = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [6:0] baddr = 7'h00, e;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, d, r32, d_rd;
	logic [9:0] code = 10'h000, acode;
	logic [15:0][7:0] mem = '0;
	logic por, nreq, nack, astart, adone, conv, anl, i2c_en, pm_en, back;
	logic awready, wready, bvalid, arready, rvalid, an, sw;
	logic [3:0] naddr;
	logic [7:0] ndata, b;
	logic [6:0] i2c_a, pm_a;
	logic [1:0] bresp, rresp, r;
	int n_fail = 0, check_count = 0, seed = 32'h0000_e0f1;
	int n_ack, n_start, i, j, k, n, c, lo, hi;
	int thr[15] = '{62, 103, 143, 186, 234, 282, 334, 390, 450, 520, 593,
		669, 744, 817, 899};
	logic [7:0] t0[6] = '{8'h10, 8'h10, 8'h00, 8'h10, 8'h10, 8'h10};
	logic [7:0] t1[6] = '{8'h40, 8'h7a, 8'h40, 8'h00, 8'h40, 8'h40};
	logic [7:0] t2[6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
	int tk[6] = '{0, 15, -1, -1, -1, 16};

	isas_init_seq u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.bias_supply_ok_i(bias_ok), .core_supply_rail_ok_i(core_ok),
		.osc_stable_i(osc_ok), .por_active_o(por), .nvm_req_o(nreq),
		.nvm_addr_o(naddr), .nvm_ack_i(nack), .nvm_data_i(ndata),
		.adc_start_o(astart), .adc_done_i(adone), .adc_code_i(acode),
		.enable_mode_pin_i(pin), .vin_uv_ok_i(uv), .convert_en_o(conv),
		.comm_pins_analog_o(anl), .i2c_addr_o(i2c_a), .i2c_en_o(i2c_en),
		.pmbus_addr_o(pm_a), .pmbus_en_o(pm_en), .bus_addr_i(baddr),
		.bus_addr_valid_i(bvld), .bus_is_pmbus_i(bpm), .bus_ack_o(back),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(d_rd),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));

	isas_nv_adc_model u_far (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.slow_i(slow), .mem_i(mem), .strap_code_i(code), .nvm_req_i(nreq),
		.nvm_addr_i(naddr), .nvm_ack_o(nack), .nvm_data_o(ndata),
		.adc_start_i(astart), .adc_done_o(adone), .adc_code_o(acode));

	// ************************************************
	// Clock, watchdog, event counters
	// ************************************************
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial begin
		#1_000_000;
		$display("Error at %0t: watchdog expired", $time);
		n_fail++;
		wrap_up;
	end
	always @(posedge mclk_i) begin
		if (nreq && nack) n_ack++;
		if (astart) n_start++;
	end

	// ************************************************
	// Compare, bus and closing tasks
	// ************************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		int t;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		t = 0;
		do begin
			@(posedge mclk_i);
			t++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && t < 50);
		r = bresp;
		bready <= 1'b0;
		chk(t < 50, 1);
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a);
		int t;
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		do begin
			@(posedge mclk_i);
			t++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && t < 50);
		d = d_rd;
		r = rresp;
		rready <= 1'b0;
		chk(t < 50, 1);
	endtask : axi_rd
	task automatic wrap_up;
		$display("Checks: %0d, mismatches: %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ************************************************
	// Main sequence: one power-up per table entry
	// ************************************************
	initial begin
		for (i = 0; i < 6; i++) begin
			k = (tk[i] < 0) ? (($random(seed) & 32'h0000_7fff) % 16) : tk[i];
			an = (k == 16);
			lo = (k == 0) ? 0 : (an ? 1000 : thr[k-1] + 1);
			hi = an ? 1023 : ((k == 15) ? 999 : thr[k] - 1);
			@(posedge mclk_i);
			resetn_i <= 1'b0;
			{bias_ok, core_ok, osc_ok} <= 3'b000;
			r32 = $random(seed);
			slow <= r32[0];
			code <= 10'(lo + (($random(seed) & 32'h0000_7fff) % (hi - lo + 1)));
			for (j = 3; j < 16; j++) mem[j] = 8'($random(seed));
			mem[0] = t0[i];
			mem[1] = t1[i];
			mem[2] = t2[i];
			repeat (16) @(posedge mclk_i);
			resetn_i <= 1'b1;
			n_ack = 0;
			n_start = 0;
			{bias_ok, core_ok, osc_ok} <= ~(3'b001 << (r32[7:0] % 3));
			repeat (3) @(posedge mclk_i);
			chk(por, 1);
			chk(nreq, 0);
			{bias_ok, core_ok, osc_ok} <= 3'b111;
			n = 0;
			while (n < 600 && !(adone && n_start != 0)) begin
				@(posedge mclk_i);
				n++;
			end
			repeat (3) @(posedge mclk_i);
			chk(n < 600, 1);
			chk(n_ack, 16);
			chk(n_start, 1);
			chk(anl, an);
			for (j = 0; j < 2; j++) begin
				b = j ? t1[i] : t0[i];
				e = b[6:0] + 7'(k);
				chk(j ? pm_en : i2c_en, b[6:0] != 0 && !an);
				if (b[6:0] != 0 && !an) chk(j ? pm_a : i2c_a, e);
				@(posedge mclk_i);
				baddr <= e;
				bpm <= j[0];
				bvld <= 1'b1;
				@(negedge mclk_i);
				chk(back, b[6:0] != 0 && !an);
				@(posedge mclk_i);
				baddr <= e ^ 7'h01;
				@(negedge mclk_i);
				chk(back, 0);
			end
			bvld <= 1'b0;
			axi_rd(REG_STATUS);
			chk(d[2:0], {an, 2'b11});
			if (!an) chk(d[11:8], k[3:0]);
			sw = !an && t2[i][0];
			for (c = 0; c < 4; c++) begin
				@(posedge mclk_i);
				pin <= c[0];
				uv <= c[1];
				repeat (3) @(posedge mclk_i);
				chk(conv, c[1] && (sw ? t2[i][1] : c[0]));
			end
			pin <= 1'b0;
			axi_wr(12'h000, 32'h0000_0025);
			chk(r, an ? RESP_SLVERR : RESP_OKAY);
			axi_rd(12'h000);
			chk(d[6:0], an ? t0[i][6:0] : 7'h25);
			repeat (2) @(posedge mclk_i);
			if (!an) chk(i2c_a, 7'h25 + 7'(k));
			axi_rd(REG_EFF_ADDR);
			chk(d[17:16], an ? 2'b00 : {t1[i][6:0] != 7'h00, 1'b1});
			if (!an) chk(d[14:0], {7'(t1[i][6:0] + 7'(k)), 1'b0,
				7'(7'h25 + 7'(k))});
			axi_rd(12'h014);
			chk(d[7:0], mem[5]);
			axi_rd(12'h080);
			chk(r, RESP_SLVERR);
			@(posedge mclk_i);
			core_ok <= 1'b0;
			repeat (3) @(posedge mclk_i);
			chk(por, 1);
			chk(conv, 0);
		end
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
